/* hdl/osi_blink.sv */
`timescale 1ns/1ps
module osi_blink #(
  parameter int HALF_CYCLES = osi_pkg::BLINK_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic blink_on
);
  import osi_pkg::*;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic phase_q;
  logic phase_d;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYCLES - 1);

  always_comb begin
    div_d = div_q + DIV_W'(1);
    phase_d = phase_q;
    if (div_q >= DIV_LAST) begin
      div_d = DIV_RST;
      phase_d = ~phase_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_q <= DIV_RST;
      phase_q <= 1'b0;
    end else begin
      div_q <= div_d;
      phase_q <= phase_d;
    end
  end

  assign blink_on = phase_q;
endmodule

/* hdl/osi_indicator.sv */
`timescale 1ns/1ps
module osi_indicator #(
  parameter int BLINK_HALF = osi_pkg::BLINK_HALF_CYCLES,
  parameter int TICK_CYCLES = osi_pkg::TIME_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic init_done,
  input wire logic path_ready,
  input wire logic device_error,
  input wire logic rx_level_low,
  input wire logic link_interrupted,
  input wire logic laser_defective,
  input wire logic [1:0] temp_class,
  input wire logic laser_eol,
  input wire logic laser_overcurrent,
  input wire logic laser_trip_clear,
  input wire logic carrier_write,
  input wire logic carrier_value,
  input wire logic overtemp_time_clear,
  output logic [1:0] supply_state_led,
  output logic [1:0] temperature_state_led,
  output logic [1:0] laser_health_led,
  output logic [1:0] carrier_select_led,
  output logic tx_enable,
  output logic rx_enable,
  output logic carrier_high,
  output logic [osi_pkg::TIME_W-1:0] overtemp_seconds
);
  import osi_pkg::*;

  logic blink_on;
  logic warn_now;
  logic ready_now;
  logic overtemp_now;
  logic [TIME_W-1:0] meter_seconds;

  osi_supply_t mode_q;
  osi_supply_t mode_d;
  logic [1:0] sup_led_q;
  logic [1:0] sup_led_d;
  logic [1:0] tmp_led_q;
  logic [1:0] tmp_led_d;
  logic [1:0] las_led_q;
  logic [1:0] las_led_d;
  logic [1:0] car_led_q;
  logic [1:0] car_led_d;
  logic trip_q;
  logic trip_d;
  logic carrier_q;
  logic carrier_d;
  logic tx_q;
  logic tx_d;
  logic rx_q;
  logic rx_d;
  logic [TIME_W-1:0] time_q;
  logic [TIME_W-1:0] time_d;

  osi_blink #(
    .HALF_CYCLES(BLINK_HALF)
  ) u_blink (
    .clock(clock),
    .rst_n(rst_n),
    .blink_on(blink_on)
  );

  osi_time_meter #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_meter (
    .clock(clock),
    .rst_n(rst_n),
    .active(overtemp_now),
    .clear(overtemp_time_clear),
    .seconds(meter_seconds)
  );

  function automatic logic [1:0] blink_colour(input logic on, input logic [1:0] colour);
    blink_colour = on ? colour : LED_OFF;
  endfunction

  assign warn_now = rx_level_low | link_interrupted | laser_defective;
  assign ready_now = init_done & path_ready;
  assign overtemp_now = (temp_class == TEMP_BEYOND);

  // Supply indicator state and colour
  always_comb begin
    if (device_error) begin
      mode_d = OSI_SUP_ERROR;
    end else if (warn_now) begin
      mode_d = OSI_SUP_WARN;
    end else if (!ready_now) begin
      mode_d = OSI_SUP_INIT;
    end else begin
      mode_d = OSI_SUP_READY;
    end
    case (mode_d)
      OSI_SUP_ERROR: begin
        sup_led_d = LED_RED;
      end
      OSI_SUP_WARN: begin
        sup_led_d = blink_colour(blink_on, LED_RED);
      end
      OSI_SUP_INIT: begin
        sup_led_d = blink_colour(blink_on, LED_GREEN);
      end
      OSI_SUP_READY: begin
        sup_led_d = LED_GREEN;
      end
      default: begin
        sup_led_d = LED_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_q <= OSI_SUP_INIT;
      sup_led_q <= LED_OFF;
    end else begin
      mode_q <= mode_d;
      sup_led_q <= sup_led_d;
    end
  end

  // Temperature indicator
  always_comb begin
    case (temp_class)
      TEMP_IN_RANGE: begin
        tmp_led_d = LED_OFF;
      end
      TEMP_NEAR: begin
        tmp_led_d = LED_ORANGE;
      end
      default: begin
        tmp_led_d = LED_RED;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tmp_led_q <= LED_OFF;
    end else begin
      tmp_led_q <= tmp_led_d;
    end
  end

  // Laser trip latch and laser health indicator; a new trip beats a clear
  always_comb begin
    trip_d = trip_q;
    if (laser_trip_clear) begin
      trip_d = 1'b0;
    end
    if (laser_overcurrent) begin
      trip_d = 1'b1;
    end
    if (trip_d) begin
      las_led_d = blink_colour(blink_on, LED_ORANGE);
    end else if (laser_eol) begin
      las_led_d = LED_ORANGE;
    end else begin
      las_led_d = LED_OFF;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trip_q <= 1'b0;
      las_led_q <= LED_OFF;
    end else begin
      trip_q <= trip_d;
      las_led_q <= las_led_d;
    end
  end

  // Carrier selection, held until rewritten
  always_comb begin
    carrier_d = carrier_write ? carrier_value : carrier_q;
    car_led_d = (carrier_d == CARRIER_HIGH) ? LED_GREEN : LED_OFF;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      carrier_q <= CARRIER_RST;
      car_led_q <= LED_GREEN;
    end else begin
      carrier_q <= carrier_d;
      car_led_q <= car_led_d;
    end
  end

  // Data path enables; temperature and laser wear never stop traffic
  always_comb begin
    rx_d = ready_now;
    tx_d = ready_now & ~trip_d;
    time_d = meter_seconds;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_q <= 1'b0;
      tx_q <= 1'b0;
      time_q <= TIME_RST;
    end else begin
      rx_q <= rx_d;
      tx_q <= tx_d;
      time_q <= time_d;
    end
  end

  assign supply_state_led = sup_led_q;
  assign temperature_state_led = tmp_led_q;
  assign laser_health_led = las_led_q;
  assign carrier_select_led = car_led_q;
  assign tx_enable = tx_q;
  assign rx_enable = rx_q;
  assign carrier_high = carrier_q;
  assign overtemp_seconds = time_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  init_no_data_a: assert property (!init_done |=> !rx_enable && !tx_enable)
    else $error("data enabled during initialisation");
  init_blink_a: assert property (
    (!device_error && !warn_now && !ready_now) |=>
    supply_state_led == ($past(blink_on) ? LED_GREEN : LED_OFF))
    else $error("supply not blinking green while initialising");
  ready_green_a: assert property (
    (!device_error && !warn_now && ready_now) |=> supply_state_led == LED_GREEN)
    else $error("supply not steady green when ready");
  warn_blink_a: assert property (
    (!device_error && warn_now) |=>
    supply_state_led == ($past(blink_on) ? LED_RED : LED_OFF))
    else $error("supply not blinking red on warning");
  error_red_a: assert property (device_error |=> supply_state_led == LED_RED)
    else $error("supply not steady red on device error");
  temp_dark_a: assert property (
    temp_class == TEMP_IN_RANGE |=> temperature_state_led == LED_OFF)
    else $error("temperature indicator lit in range");
  temp_orange_a: assert property (
    temp_class == TEMP_NEAR && ready_now && !trip_d |=>
    temperature_state_led == LED_ORANGE && tx_enable)
    else $error("near-range temperature not orange or traffic stopped");
  temp_red_a: assert property (
    temp_class == TEMP_BEYOND && ready_now && !trip_d |=>
    temperature_state_led == LED_RED && tx_enable)
    else $error("beyond-range temperature not red or traffic stopped");
  time_hold_a: assert property (
    (!overtemp_now && !overtemp_time_clear) |->
    ##2 overtemp_seconds == $past(overtemp_seconds))
    else $error("overtemperature time moved while in range");
  laser_dark_a: assert property (
    !trip_d && !laser_eol |=> laser_health_led == LED_OFF)
    else $error("laser indicator lit with reserve");
  laser_eol_a: assert property (
    !trip_d && laser_eol |=> laser_health_led == LED_ORANGE)
    else $error("laser end of life not steady orange");
  trip_off_a: assert property (
    laser_overcurrent |=> !tx_enable &&
    laser_health_led == ($past(blink_on) ? LED_ORANGE : LED_OFF))
    else $error("overcurrent did not stop transmitter or blink orange");
  trip_hold_a: assert property (
    trip_q && !laser_trip_clear |=> trip_q [*2] or (trip_q ##1 laser_trip_clear))
    else $error("laser trip dropped without clear");
  carrier_led_a: assert property (
    carrier_write |=> carrier_select_led == ($past(carrier_value) ? LED_GREEN : LED_OFF))
    else $error("carrier indicator does not follow selection");
  carrier_reset_a: assert property (
    !$past(rst_n) |-> carrier_high == CARRIER_HIGH && carrier_select_led == LED_GREEN)
    else $error("carrier selection not high after reset");
  carrier_hold_a: assert property (
    !carrier_write |=> carrier_high == $past(carrier_high))
    else $error("carrier selection moved without a write");

  // Supply state register, priority and colour agree
  supply_err_mode_a: assert property (device_error |=> mode_q == OSI_SUP_ERROR)
    else $error("device error did not win supply priority");
  supply_warn_mode_a: assert property (
    (!device_error && warn_now) |=> mode_q == OSI_SUP_WARN)
    else $error("warning did not win over initialisation");
  ready_mode_led_a: assert property (
    mode_q == OSI_SUP_READY |-> supply_state_led == LED_GREEN)
    else $error("ready state without steady green");
  error_mode_led_a: assert property (
    mode_q == OSI_SUP_ERROR |-> supply_state_led == LED_RED)
    else $error("error state without steady red");

  // Temperature, laser and data path
  temp_code3_a: assert property (
    temp_class == 2'h3 |=> temperature_state_led == LED_RED)
    else $error("temperature code 3 not shown red");
  time_clear_a: assert property (
    (overtemp_time_clear && !overtemp_now) |-> ##2 overtemp_seconds == TIME_RST)
    else $error("overtemperature time not cleared");
  eol_runs_a: assert property (
    laser_eol && ready_now && !trip_d |=> tx_enable)
    else $error("laser end of life stopped traffic");
  trip_tx_off_a: assert property (trip_q |-> !tx_enable)
    else $error("transmitter on while laser tripped");
  trip_clear_a: assert property (
    trip_q && laser_trip_clear && !laser_overcurrent |=> !trip_q)
    else $error("laser trip not cleared");
endmodule

/* hdl/osi_pkg.sv */
package osi_pkg;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_HALF_CYCLES = (CLK_FREQ_HZ / 1000) * BLINK_HALF_MS;
  localparam int TIME_TICK_S = 1;
  localparam int TIME_TICK_CYCLES = CLK_FREQ_HZ * TIME_TICK_S;
  localparam int TEMP_MARGIN_C = 5;
  localparam int DIV_W = 27;
  localparam int TIME_W = 32;
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_ORANGE = 2'h2;
  localparam logic [1:0] LED_RED = 2'h3;
  localparam logic [1:0] TEMP_IN_RANGE = 2'h0;
  localparam logic [1:0] TEMP_NEAR = 2'h1;
  localparam logic [1:0] TEMP_BEYOND = 2'h2;
  localparam logic CARRIER_LOW = 1'h0;
  localparam logic CARRIER_HIGH = 1'h1;
  localparam logic CARRIER_RST = CARRIER_HIGH;
  localparam logic [TIME_W-1:0] TIME_RST = 32'h0;
  localparam logic [DIV_W-1:0] DIV_RST = 27'h0;
  typedef enum logic [1:0] {OSI_SUP_INIT, OSI_SUP_READY, OSI_SUP_WARN, OSI_SUP_ERROR} osi_supply_t;
endpackage

/* hdl/osi_time_meter.sv */
`timescale 1ns/1ps
module osi_time_meter #(
  parameter int TICK_CYCLES = osi_pkg::TIME_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic active,
  input wire logic clear,
  output logic [osi_pkg::TIME_W-1:0] seconds
);
  import osi_pkg::*;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [TIME_W-1:0] sec_q;
  logic [TIME_W-1:0] sec_d;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  // Saturating count of whole seconds while active; clear loses to a tick
  always_comb begin
    div_d = div_q;
    sec_d = clear ? TIME_RST : sec_q;
    if (active) begin
      div_d = div_q + DIV_W'(1);
      if (div_q >= DIV_LAST) begin
        div_d = DIV_RST;
        if (sec_q != {TIME_W{1'b1}}) begin
          sec_d = sec_q + TIME_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_q <= DIV_RST;
      sec_q <= TIME_RST;
    end else begin
      div_q <= div_d;
      sec_q <= sec_d;
    end
  end

  assign seconds = sec_q;
endmodule

/* sim/test_operating_state_indicator.sv */
`timescale 1ns/1ps
module test_operating_state_indicator;
  import osi_pkg::*;
  localparam int HALF = 4;
  localparam int TICK = 5;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic init_done, path_ready, device_error, rx_level_low, link_interrupted, laser_defective;
  logic laser_eol, laser_overcurrent, laser_trip_clear, carrier_write, carrier_value;
  logic overtemp_time_clear;
  logic [1:0] temp_class;
  logic [1:0] supply_state_led, temperature_state_led, laser_health_led, carrier_select_led;
  logic tx_enable, rx_enable, carrier_high;
  logic [TIME_W-1:0] overtemp_seconds;
  logic [TIME_W-1:0] held;
  logic trip_m, carrier_m;
  integer seed = 32'hF7B3FF19;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Corner vectors: init, path, err, low, link, lasdef, temp[2], eol, oc, clr, cw, cv, otclr
  logic [13:0] corner [20] = '{14'h0000, 14'h3000, 14'h3400, 14'h3200, 14'h3100, 14'h0200,
    14'h3C00, 14'h3040, 14'h3080, 14'h30C0, 14'h3020, 14'h3030, 14'h3020, 14'h3038,
    14'h3028, 14'h3020, 14'h3004, 14'h3000, 14'h3006, 14'h3000};

  osi_indicator #(.BLINK_HALF(HALF), .TICK_CYCLES(TICK)) osi_indicator_inst (
    .clock(clock), .rst_n(rst_n), .init_done(init_done), .path_ready(path_ready),
    .device_error(device_error), .rx_level_low(rx_level_low),
    .link_interrupted(link_interrupted), .laser_defective(laser_defective),
    .temp_class(temp_class), .laser_eol(laser_eol), .laser_overcurrent(laser_overcurrent),
    .laser_trip_clear(laser_trip_clear), .carrier_write(carrier_write),
    .carrier_value(carrier_value), .overtemp_time_clear(overtemp_time_clear),
    .supply_state_led(supply_state_led), .temperature_state_led(temperature_state_led),
    .laser_health_led(laser_health_led), .carrier_select_led(carrier_select_led),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .carrier_high(carrier_high),
    .overtemp_seconds(overtemp_seconds));

  always #5 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic drive(input logic [13:0] v);
    {init_done, path_ready, device_error, rx_level_low, link_interrupted, laser_defective,
     temp_class, laser_eol, laser_overcurrent, laser_trip_clear, carrier_write, carrier_value,
     overtemp_time_clear} = v;
  endtask

  // Blink flag and colour of the supply indicator
  function automatic logic [2:0] exp_supply();
    if (device_error) return {1'b0, LED_RED};
    if (rx_level_low | link_interrupted | laser_defective) return {1'b1, LED_RED};
    if (!(init_done & path_ready)) return {1'b1, LED_GREEN};
    return {1'b0, LED_GREEN};
  endfunction

  function automatic logic [1:0] exp_temp();
    if (temp_class == TEMP_IN_RANGE) return LED_OFF;
    if (temp_class == TEMP_NEAR) return LED_ORANGE;
    return LED_RED;
  endfunction

  function automatic logic [2:0] exp_laser();
    if (trip_m) return {1'b1, LED_ORANGE};
    if (laser_eol) return {1'b0, LED_ORANGE};
    return {1'b0, LED_OFF};
  endfunction

  // Holds the driven inputs for one blink period plus three cycles and checks every output but overtemp_seconds
  task automatic hold_check();
    logic [2:0] es, el;
    logic [3:0] seen_f;
    seen_f = 4'h0;
    tick();
    trip_m = laser_overcurrent | (trip_m & !laser_trip_clear);
    if (carrier_write) carrier_m = carrier_value;
    es = exp_supply();
    el = exp_laser();
    for (int i = 0; i < 2 * HALF + 2; i++) begin
      check(temperature_state_led, exp_temp());
      check(rx_enable, init_done & path_ready);
      check(tx_enable, init_done & path_ready & !trip_m);
      check(carrier_high, carrier_m);
      check(carrier_select_led, carrier_m ? LED_GREEN : LED_OFF);
      check(supply_state_led, es[2] && supply_state_led === LED_OFF ? LED_OFF : es[1:0]);
      check(laser_health_led, el[2] && laser_health_led === LED_OFF ? LED_OFF : el[1:0]);
      seen_f = seen_f | {supply_state_led === LED_OFF, supply_state_led !== LED_OFF,
                         laser_health_led === LED_OFF, laser_health_led !== LED_OFF};
      tick();
    end
    if (es[2]) check(seen_f[3:2], 2'h3);
    if (el[2]) check(seen_f[1:0], 2'h3);
  endtask

  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    drive(14'h0000);
    trip_m = 1'b0;
    carrier_m = 1'b1;
    repeat (5) tick();
    check({supply_state_led, temperature_state_led, laser_health_led}, 6'h00);
    check({carrier_select_led, carrier_high, tx_enable, rx_enable}, 5'h0C);
    rst_n = 1'b1;
    foreach (corner[i]) begin
      drive(corner[i]);
      hold_check();
    end
    for (int i = 0; i < 30; i++) begin
      drive(14'($random(seed)));
      hold_check();
    end
    drive(14'h3001);
    repeat (4) tick();
    check(overtemp_seconds, 32'h0);
    drive(14'h3080);
    repeat (6 * TICK) tick();
    check(overtemp_seconds >= 5 && overtemp_seconds <= 6, 1'b1);
    drive(14'h3040);
    repeat (4) tick();
    held = overtemp_seconds;
    repeat (3 * TICK) tick();
    check(overtemp_seconds, held);
    // Carrier_low, opposite the factory setting of the facing unit
    drive(14'h3004);
    hold_check();
    rst_n = 1'b0;
    repeat (2) tick();
    check({carrier_high, tx_enable, overtemp_seconds == 0}, 3'h5);
    rst_n = 1'b1;
    tick();
    // Reset cleared the trip; the held write selects carrier_low again
    check({carrier_high, tx_enable, supply_state_led}, {1'b0, 1'b1, LED_GREEN});
    report_and_stop();
  end
endmodule
